/* verilog/rsp_pkg.sv */
// Constants for the return stack pointer block
//
// Notes on behaviour
// - Software reads and writes the top entry through upper, high and low byte registers.
// - Push increments the pointer and stores the current program counter as new top.
// - Pop discards the top entry by decrementing the pointer.
// - Pointer register bit 7 reads 1 once the stack became full or overflowed.
// - Pointer register bit 6 reads 1 after an underflow occurred.
// - Pointer register bit 5 is unimplemented and reads zero.
// - Low five bits hold the pointer, software read/write, reset to zero.
// - Both flags are cleared only by software or power-on reset.
// - Pointer increments before a push write, decrements after a pop read.
// - With overflow reset on, 31st push stores pc+2, sets full, resets, pointer zero.
// - With overflow reset off, 31st push sets full; later pushes keep pointer and entries, set full again.
// - Pop from empty returns zero, sets underflow, pointer stays zero.
package rsp_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W   = 21;
  localparam int unsigned LVL_W  = 5;
  localparam int unsigned DEPTH  = 32;

  // Register offsets
  localparam logic [3:0] OFS_TOP_UPPER  = 4'h0;
  localparam logic [3:0] OFS_TOP_HIGH   = 4'h1;
  localparam logic [3:0] OFS_TOP_LOW    = 4'h2;
  localparam logic [3:0] OFS_STACK_PTR  = 4'h3;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_CLEAR  = 4'h5;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'h6;

  // Pointer register fields
  localparam int unsigned FULL_BIT  = 7;
  localparam int unsigned UNDER_BIT = 6;
  localparam int unsigned UPPER_W   = 5;

  // Interrupt status bits
  localparam int unsigned IRQ_W         = 2;
  localparam int unsigned IRQ_FULL_BIT  = 0;
  localparam int unsigned IRQ_UNDER_BIT = 1;

  // Levels and reset values
  localparam logic [4:0]  LVL_EMPTY  = 5'h00;
  localparam logic [4:0]  LVL_FULL   = 5'h1f;
  localparam logic [4:0]  LVL_LAST   = 5'h1e;
  localparam logic [20:0] PC_STEP    = 21'h000002;
  localparam logic [20:0] PC_ZERO    = 21'h000000;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [1:0]  IRQ_ZERO   = 2'h0;

endpackage

/* verilog/rsp_stack_mem.sv */
// Flip-flop storage for the return stack entries
`timescale 1ns/1ps
`default_nettype none
module rsp_stack_mem (
  input  wire logic                         clk_sys,  // Core clock
  input  wire logic                         rst,      // Synchronous reset
  input  wire logic                         wr_en,    // Write one entry
  input  wire logic [rsp_pkg::LVL_W-1:0]    wr_idx,   // Entry written
  input  wire logic [rsp_pkg::PC_W-1:0]     wr_data,  // Value written
  input  wire logic [rsp_pkg::LVL_W-1:0]    rd_idx,   // Entry read
  output logic      [rsp_pkg::PC_W-1:0]     rd_data   // Value read, combinational
);
  import rsp_pkg::*;

  logic [PC_W-1:0] entry      [DEPTH];
  logic [PC_W-1:0] next_entry [DEPTH];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_entry[i] = entry[i];
    end
    if (wr_en) begin
      next_entry[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (rst) begin
        entry[i] <= PC_ZERO;
      end else begin
        entry[i] <= next_entry[i];
      end
    end
  end

  assign rd_data = entry[rd_idx];

endmodule
`default_nettype wire

/* verilog/rsp_return_stack.sv */
// Return stack pointer, top-entry registers and stack events
`timescale 1ns/1ps
`default_nettype none
module rsp_return_stack (
  input  wire logic                        clk_sys,               // Core clock, 20 MHz
  input  wire logic                        rst,                   // Power-on reset, synchronous
  input  wire logic                        push,                  // Push pulse from sequencer
  input  wire logic                        pop,                   // Pop pulse from sequencer
  input  wire logic [rsp_pkg::PC_W-1:0]    pc_in,                 // Current program counter
  input  wire logic                        overflow_reset_enable, // Configuration option
  input  wire logic [rsp_pkg::ADDR_W-1:0]  addr,                  // Register address
  input  wire logic [rsp_pkg::DATA_W-1:0]  wr_data,               // Register write data
  input  wire logic                        wr_en,                 // Register write strobe
  input  wire logic                        rd_en,                 // Register read strobe
  output logic      [rsp_pkg::DATA_W-1:0]  rd_data,               // Read data, cycle after strobe
  output logic      [rsp_pkg::PC_W-1:0]    pop_pc,                // Value returned by a pop
  output logic                             pop_valid,             // Pop result pulse
  output logic                             dev_reset_req,         // Device reset request pulse
  output logic                             irq                    // Level interrupt
);
  import rsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Sticky flag: set wins, software clears only with a written zero
  function automatic logic sticky(input logic cur, input logic set_ev,
                                  input logic sw_wr, input logic sw_bit);
    logic res;
    res = cur;
    if (sw_wr && !sw_bit) begin
      res = 1'b0;
    end
    if (set_ev) begin
      res = 1'b1;
    end
    return res;
  endfunction

  // Address match on the register port
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction

  // Level arithmetic wraps in five bits; callers guard both ends
  function automatic logic [LVL_W-1:0] step(input logic [LVL_W-1:0] lvl, input logic up);
    logic [LVL_W-1:0] res;
    res = up ? lvl + 5'h01 : lvl - 5'h01;
    return res;
  endfunction

  // Byte write into the top entry, the other bytes kept
  function automatic logic [PC_W-1:0] put_byte(input logic [PC_W-1:0]   cur,
                                                input logic [1:0]        sel,
                                                input logic [DATA_W-1:0] b);
    logic [PC_W-1:0] res;
    res = cur;
    case (sel)
      2'h0: begin
        res[PC_W-1:16] = b[UPPER_W-1:0];
      end
      2'h1: begin
        res[15:8] = b;
      end
      default: begin
        res[7:0] = b;
      end
    endcase
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [LVL_W-1:0] stack_level;
  logic             stack_full_flag;
  logic             stack_underflow_flag;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;

  logic [LVL_W-1:0] next_stack_level;
  logic             next_stack_full_flag;
  logic             next_stack_underflow_flag;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] next_irq_enable;
  logic [DATA_W-1:0] next_rd_data;
  logic [PC_W-1:0]  next_pop_pc;
  logic             next_pop_valid;
  logic             next_dev_reset_req;
  logic             next_irq;

  // Storage port
  logic             mem_wr;
  logic [LVL_W-1:0] mem_wr_idx;
  logic [PC_W-1:0]  mem_wr_data;
  logic [PC_W-1:0]  top_entry;

  rsp_stack_mem u_mem (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wr_en   (mem_wr),
    .wr_idx  (mem_wr_idx),
    .wr_data (mem_wr_data),
    .rd_idx  (stack_level),
    .rd_data (top_entry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic wr_upper;
  logic wr_high;
  logic wr_low;
  logic wr_ptr;
  logic wr_clr;
  logic wr_ena;

  assign wr_upper = wr_en && hit(addr, OFS_TOP_UPPER);
  assign wr_high  = wr_en && hit(addr, OFS_TOP_HIGH);
  assign wr_low   = wr_en && hit(addr, OFS_TOP_LOW);
  assign wr_ptr   = wr_en && hit(addr, OFS_STACK_PTR);
  assign wr_clr   = wr_en && hit(addr, OFS_IRQ_CLEAR);
  assign wr_ena   = wr_en && hit(addr, OFS_IRQ_ENABLE);

  ////////////////////////////////////////////////////////////////////////////
  // Stack operations

  logic do_push;
  logic do_pop;
  logic at_top;
  logic at_empty;
  logic full_ev;
  logic under_ev;

  // Push wins if the sequencer ever raises both
  assign do_push  = push;
  assign do_pop   = pop && !push;
  assign at_top   = stack_level == LVL_FULL;
  assign at_empty = stack_level == LVL_EMPTY;
  // A push at level 31 counts again, so the flag re-arms after a clear
  assign full_ev  = do_push && (at_top || stack_level == LVL_LAST);
  assign under_ev = do_pop && at_empty;

  always_comb begin
    next_stack_level   = stack_level;
    next_pop_pc        = PC_ZERO;
    next_pop_valid     = 1'b0;
    next_dev_reset_req = 1'b0;
    mem_wr             = 1'b0;
    mem_wr_idx         = stack_level;
    mem_wr_data        = top_entry;

    if (wr_ptr) begin
      next_stack_level = wr_data[LVL_W-1:0];
    end

    if (wr_upper) begin
      mem_wr      = 1'b1;
      mem_wr_data = put_byte(top_entry, 2'h0, wr_data);
    end else if (wr_high) begin
      mem_wr      = 1'b1;
      mem_wr_data = put_byte(top_entry, 2'h1, wr_data);
    end else if (wr_low) begin
      mem_wr      = 1'b1;
      mem_wr_data = put_byte(top_entry, 2'h2, wr_data);
    end

    if (do_push) begin
      if (at_top) begin
        // no overwrite once the last entry is used
        next_stack_level = stack_level;
        mem_wr           = 1'b0;
        if (overflow_reset_enable) begin
          // overflow with reset option also resets here
          next_stack_level   = LVL_EMPTY;
          next_dev_reset_req = 1'b1;
        end
      end else begin
        // increment first, then store the counter
        next_stack_level = step(stack_level, 1'b1);
        mem_wr           = 1'b1;
        mem_wr_idx       = step(stack_level, 1'b1);
        mem_wr_data      = pc_in;
        if (stack_level == LVL_LAST && overflow_reset_enable) begin
          // 31st push stores pc+2 and resets
          mem_wr_data        = pc_in + PC_STEP;
          next_stack_level   = LVL_EMPTY;
          next_dev_reset_req = 1'b1;
        end
      end
    end else if (do_pop) begin
      next_pop_valid = 1'b1;
      if (at_empty) begin
        // empty pop returns zero and holds level
        next_pop_pc      = PC_ZERO;
        next_stack_level = LVL_EMPTY;
      end else begin
        next_pop_pc      = top_entry;
        next_stack_level = step(stack_level, 1'b0);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt

  always_comb begin
    next_stack_full_flag = sticky(stack_full_flag, full_ev, wr_ptr, wr_data[FULL_BIT]);
    next_stack_underflow_flag = sticky(stack_underflow_flag, under_ev, wr_ptr,
                                       wr_data[UNDER_BIT]);

    next_irq_enable = irq_enable;
    if (wr_ena) begin
      next_irq_enable = wr_data[IRQ_W-1:0];
    end

    next_irq_status = irq_status;
    if (wr_clr) begin
      next_irq_status = irq_status & ~wr_data[IRQ_W-1:0];
    end
    // New events beat a clear in the same cycle
    if (full_ev) begin
      next_irq_status[IRQ_FULL_BIT] = 1'b1;
    end
    if (under_ev) begin
      next_irq_status[IRQ_UNDER_BIT] = 1'b1;
    end

    next_irq = |(next_irq_status & next_irq_enable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    next_rd_data = BYTE_ZERO;
    if (rd_en) begin
      case (addr)
        OFS_TOP_UPPER:  next_rd_data = {3'h0, top_entry[20:16]};
        OFS_TOP_HIGH:   next_rd_data = top_entry[15:8];
        OFS_TOP_LOW:    next_rd_data = top_entry[7:0];
        OFS_STACK_PTR:  next_rd_data = {stack_full_flag, stack_underflow_flag, 1'b0, stack_level};
        OFS_IRQ_STATUS: next_rd_data = {6'h00, irq_status};
        OFS_IRQ_ENABLE: next_rd_data = {6'h00, irq_enable};
        // Unmapped and write-only offsets read zero
        default:        next_rd_data = BYTE_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack registers

  // Outputs registered, so the sequencer always sees settled values
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stack_level   <= LVL_EMPTY;
      pop_pc        <= PC_ZERO;
      pop_valid     <= 1'b0;
      dev_reset_req <= 1'b0;
    end else begin
      stack_level   <= next_stack_level;
      pop_pc        <= next_pop_pc;
      pop_valid     <= next_pop_valid;
      dev_reset_req <= next_dev_reset_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag and interrupt registers

  // Power-on reset is the only hardware path that clears the flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stack_full_flag      <= 1'b0;
      stack_underflow_flag <= 1'b0;
      irq_status           <= IRQ_ZERO;
      irq_enable           <= IRQ_ZERO;
      irq                  <= 1'b0;
    end else begin
      stack_full_flag      <= next_stack_full_flag;
      stack_underflow_flag <= next_stack_underflow_flag;
      irq_status           <= next_irq_status;
      irq_enable           <= next_irq_enable;
      irq                  <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data register

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= BYTE_ZERO;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule
`default_nettype wire

/* verif/rsp_seq_model.sv */
// Sequencer model issuing push and pop pulses
`timescale 1ns/1ps
`default_nettype none
module rsp_seq_model (
  input  wire logic                     clk_sys, // Core clock
  input  wire logic                     rst,     // Reset
  input  wire logic [1:0]               cmd,     // Bit 0 push, bit 1 pop
  input  wire logic [rsp_pkg::PC_W-1:0] cmd_pc,  // Counter to push
  output logic                          push,    // Push pulse
  output logic                          pop,     // Pop pulse
  output logic      [rsp_pkg::PC_W-1:0] pc_in    // Counter bus
);
  import rsp_pkg::*;
  // Idle bus toggles, so a stale counter is never taken for a fresh one
  always_ff @(posedge clk_sys) begin
    push  <= !rst && cmd[0];
    pop   <= !rst && cmd[1];
    pc_in <= rst ? PC_ZERO : cmd[0] ? cmd_pc : ~pc_in;
  end
endmodule
`default_nettype wire

/* verif/rsp_return_stack_monitor.sv */
// Port checks for the return stack block
`timescale 1ns/1ps
`default_nettype none
module rsp_return_stack_monitor (
  input wire logic                       clk_sys,               // Clock
  input wire logic                       rst,                   // Reset
  input wire logic                       push,                  // Push
  input wire logic                       pop,                   // Pop
  input wire logic                       overflow_reset_enable, // Option
  input wire logic [rsp_pkg::ADDR_W-1:0] addr,                  // Address
  input wire logic                       rd_en,                 // Read
  input wire logic [rsp_pkg::DATA_W-1:0] rd_data,               // Data
  input wire logic [rsp_pkg::PC_W-1:0]   pop_pc,                // Pop value
  input wire logic                       pop_valid,             // Pop done
  input wire logic                       dev_reset_req          // Reset req
);
  import rsp_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_POP_ANSWER: assert property (pop && !push |=> pop_valid) else $error("pop lost");
  AST_POP_ONLY: assert property (!pop || push |=> !pop_valid) else $error("stray pop");
  AST_POP_PC_IDLE: assert property (!pop_valid |-> pop_pc == '0) else $error("pop value");
  AST_REQ_CAUSE: assert property (dev_reset_req |-> $past(push) && $past(overflow_reset_enable))
    else $error("stray reset");
  AST_NO_REQ_OFF: assert property (push && !overflow_reset_enable |=> !dev_reset_req)
    else $error("reset with option off");
  AST_UNIMP_ZERO: assert property (rd_en && addr == OFS_STACK_PTR |=> !rd_data[5])
    else $error("bit 5 set");
  AST_UPPER_ZERO: assert property (rd_en && addr == OFS_TOP_UPPER |=> rd_data[7:5] == 3'h0)
    else $error("upper bits set");
  AST_RD_IDLE: assert property (!rd_en |=> rd_data == '0) else $error("idle data");
  COV_PUSH: cover property (push);
  COV_POP: cover property (pop_valid);
  COV_REQ: cover property (dev_reset_req);
  COV_BOTH: cover property (push && pop);
endmodule
bind rsp_return_stack rsp_return_stack_monitor u_mon (.clk_sys, .rst, .push, .pop, .overflow_reset_enable,
  .addr, .rd_en, .rd_data, .pop_pc, .pop_valid, .dev_reset_req);
`default_nettype wire

/* verif/rsp_return_stack_tb_top.sv */
// Self-checking bench for the return stack block
`timescale 1ns/1ps
`default_nettype none
module rsp_return_stack_tb_top;
  import rsp_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic [1:0]        cmd = 2'h0;
  logic [PC_W-1:0]   cmd_pc = '0;
  logic              overflow_reset_enable = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic              push, pop, pop_valid, dev_reset_req, irq;
  logic [PC_W-1:0]   pc_in, pop_pc;
  logic [DATA_W-1:0] rd_data;
  int                n_errors = 0;
  int                n_tests = 0;
  int                cycles = 0;

  always #25 clk_sys = ~clk_sys;

  rsp_seq_model u_seq (.clk_sys, .rst, .cmd, .cmd_pc, .push, .pop, .pc_in);
  rsp_return_stack u_dut (.clk_sys, .rst, .push, .pop, .pc_in, .overflow_reset_enable, .addr,
    .wr_data, .wr_en, .rd_en, .rd_data, .pop_pc, .pop_valid, .dev_reset_req, .irq);

  ////////////////////////////////////////
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 chk({16'h0000, rd_data}, {16'h0000, e});
  endtask

  // Result is pop_valid, dev_reset_req, pop_pc one cycle after the op
  task automatic op(input logic [1:0] k, input logic [20:0] p, input logic [22:0] e);
    @(posedge clk_sys);
    cmd <= k;
    cmd_pc <= p;
    @(posedge clk_sys);
    cmd <= 2'h0;
    @(posedge clk_sys);
    #1 chk({1'b0, pop_valid, dev_reset_req, pop_pc}, {1'b0, e});
  endtask

  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 1500) begin
      n_errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFS_STACK_PTR, 8'h00);
    rd(OFS_IRQ_STATUS, 8'h00);
    op(2'h1, 21'h1abcde, '0);
    rd(OFS_STACK_PTR, 8'h01);
    rd(OFS_TOP_UPPER, 8'h1a);
    rd(OFS_TOP_HIGH, 8'hbc);
    wr(OFS_TOP_LOW, 8'h5a);
    op(2'h2, '0, {2'b10, 21'h1abc5a});
    op(2'h2, '0, {2'b10, PC_ZERO});
    rd(OFS_STACK_PTR, 8'h40);
    wr(OFS_IRQ_ENABLE, 8'h02);
    rd(OFS_IRQ_STATUS, 8'h02);
    chk({23'h0, irq}, 24'h1);
    wr(OFS_STACK_PTR, 8'hff);
    rd(OFS_STACK_PTR, 8'h5f);
    wr(OFS_STACK_PTR, 8'h00);
    rd(OFS_STACK_PTR, 8'h00);
    wr(OFS_IRQ_CLEAR, 8'h02);
    rd(OFS_IRQ_CLEAR, 8'h00);
    rd(4'hf, 8'h00);
    chk({23'h0, irq}, 24'h0);
    for (int i = 1; i <= 31; i++) begin
      op(2'h1, 21'(i), '0);
    end
    rd(OFS_STACK_PTR, 8'h9f);
    op(2'h1, 21'h001234, '0);
    rd(OFS_TOP_LOW, 8'h1f);
    wr(OFS_IRQ_ENABLE, 8'h01);
    rd(OFS_STACK_PTR, 8'h9f);
    chk({23'h0, irq}, 24'h1);
    wr(OFS_STACK_PTR, 8'h00);
    overflow_reset_enable <= 1'b1;
    for (int i = 1; i <= 31; i++) begin
      op(2'h1, 21'(i), (i == 31) ? 23'h200000 : '0);
    end
    rd(OFS_STACK_PTR, 8'h80);
    wr(OFS_STACK_PTR, 8'h9f);
    rd(OFS_TOP_LOW, 8'h21);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFS_STACK_PTR, 8'h00);
    chk({23'h0, irq}, 24'h0);
    wr(OFS_STACK_PTR, 8'h1f);
    rd(OFS_TOP_LOW, 8'h00);
    wr(OFS_STACK_PTR, 8'h00);
    op(2'h3, 21'h000777, '0);
    rd(OFS_TOP_LOW, 8'h77);
    rd(OFS_STACK_PTR, 8'h01);
    end_sim();
  end
endmodule
`default_nettype wire
